// ===== inc/fsr_pkg.sv
// shared constants for the serial flash status and read logic
package fsr_pkg;
  // clock and timing
  localparam int CLK_NS  = 100;
  localparam int TW_NS   = 5000000;
  localparam int CE_NS   = 10000000;
  localparam int HALF_NS = 1200;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  // opcodes
  localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_SET_LATCH    = 8'h06;
  localparam logic [7:0] CMD_CLR_LATCH    = 8'h04;
  localparam logic [7:0] CMD_ARRAY_READ   = 8'h03;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h60;
  localparam logic [7:0] CMD_OTP_ENTER    = 8'h3A;
  // geometry
  localparam int ADDR_W  = 19;
  localparam int OPC_BITS  = 8;
  localparam int ADDR_BITS = 24;
  // status layout and reset values
  localparam int ST_LOCK_B = 7;
  localparam int ST_PDIS_B = 6;
  localparam int ST_BP_LO  = 2;
  localparam logic [3:0] PIN_RST = 4'hA;  // {wp_n, serial_in, cs_n, sclk}
  localparam logic       NV_RST  = 1'h0;
  // host register map (byte addresses)
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_CTRL  = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;
  localparam int CMD_ADDR_B = 8;
  localparam int CMD_DATA_B = 9;
  localparam int CMD_RCNT_LO = 16;

  // a change counts once the second and third stages agree
  function automatic logic [3:0] fsr_filt(input logic [3:0] s2, input logic [3:0] s3,
                                          input logic [3:0] old);
    return (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
  endfunction : fsr_filt
endpackage : fsr_pkg

// ===== inc/fsr_spi_if.sv
// serial link between flash device and host controller
`timescale 1ns/1ns
interface fsr_spi_if;
  logic sclk;
  logic chip_sel_n;
  logic serial_in;
  logic wp_n;
  logic serial_out;
  logic serial_out_oe;
  logic miso;
  // undriven output line is modelled as pulled high
  assign miso = serial_out_oe ? serial_out : 1'b1;
  modport dev  (input sclk, chip_sel_n, serial_in, wp_n, output serial_out, serial_out_oe);
  modport host (output sclk, chip_sel_n, serial_in, wp_n, input miso);
endinterface : fsr_spi_if

// ===== rtl/fsr_array.sv
// byte array with preload port and combinational read
`timescale 1ns/1ns
module fsr_array import fsr_pkg::*; (
  // clock
  input  wire logic              pclk,
  // preload
  input  wire logic              load_en,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [7:0]        load_data,
  // read
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge pclk) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : fsr_array

// ===== rtl/fsr_flash_dev.sv
// flash device end: status register, status write cycle and array read
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Function
// - status read answered at any time
// - status byte repeats while select stays low
// - host polls busy before new commands; the host controller starts frames without reading the busy bit
// - busy flag high during write cycles
// - cleared latch refuses status write, erase
// - protect bits set only by status write
// - chip erase only when protect bits zero
// - protect bits rewritable outside hardware protection
// - pin disable bit ignores protect pin
// - lock bit plus low pin protects
// - OTP lock bit sets only once
// - OTP status write just sets lock
// - latch must be set before status write
// - status write needs exactly eight data bits
// - status write keeps latch and busy bits
// - select rise starts timed write cycle
// - read: opcode, 24-bit address, falling-edge data
// - read address increments and wraps to zero
// - select high ends read at once
// - read refused during a write cycle
// - set-latch command sets the latch
// - clear-latch command clears latch and exits OTP mode
module fsr_flash_dev import fsr_pkg::*; #(
  parameter int WR_CYC = TW_NS / CLK_NS,
  parameter int CE_CYC = CE_NS / CLK_NS
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // link
  fsr_spi_if.dev                 spi,
  // array preload
  input  wire logic              load_en,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [7:0]        load_data,
  // state view
  output logic      [7:0]        status_q,
  output logic                   otp_mode_q
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_WDATA, ST_ARMED, ST_STAT, ST_READ, ST_SKIP
  } fsr_dst_t;

  logic [3:0]        sy1_r, sy2_r, sy3_r, pin_r, pin_nxt;
  fsr_dst_t          st_r, st_nxt;
  logic [7:0]        sh_r, sh_nxt, op_r, op_nxt, tx_r, tx_nxt;
  logic [4:0]        cnt_r, cnt_nxt;
  logic [2:0]        ocnt_r, ocnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic              so_r, so_nxt, oe_r, oe_nxt;
  logic              srp_r, srp_nxt, lock_r, lock_nxt, pdis_r, pdis_nxt;
  logic [3:0]        bp_r, bp_nxt;
  logic              wel_r, wel_nxt, busy_r, busy_nxt, otp_r, otp_nxt;
  logic [31:0]       tmr_r, tmr_nxt;
  logic [7:0]        stat_now, mem_q, src;
  logic              sclk_rise, sclk_fall, cs_hi, cs_fall, si, hardware_protected_mode;
  logic [7:0]        sh_rx;

  fsr_array u_array (
    .pclk      (pclk),
    .load_en   (load_en),
    .load_addr (load_addr),
    .load_data (load_data),
    .rd_addr   (addr_r),
    .rd_data   (mem_q)
  );

  // pins pass three flops; the first stage feeds only the second
  assign pin_nxt   = fsr_filt(sy2_r, sy3_r, pin_r);
  assign sclk_rise = pin_nxt[0] & ~pin_r[0];
  assign sclk_fall = ~pin_nxt[0] & pin_r[0];
  assign cs_hi     = pin_nxt[1];
  assign cs_fall   = ~pin_nxt[1] & pin_r[1];
  assign si        = pin_nxt[2];
  // protect pin counts only while pin functions are enabled
  assign hardware_protected_mode       = srp_r & ~pdis_r & ~pin_nxt[3];
  // bit 7 shows the OTP lock while in OTP mode
  assign stat_now  = {otp_r ? lock_r : srp_r, pdis_r, bp_r, wel_r, busy_r};
  assign src       = (st_r == ST_STAT) ? stat_now : mem_q;
  assign sh_rx     = {sh_r[6:0], si};

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    tx_nxt = tx_r;
    cnt_nxt = cnt_r;
    ocnt_nxt = ocnt_r;
    addr_nxt = addr_r;
    so_nxt = so_r;
    oe_nxt = oe_r;
    srp_nxt = srp_r;
    lock_nxt = lock_r;
    pdis_nxt = pdis_r;
    bp_nxt = bp_r;
    wel_nxt = wel_r;
    busy_nxt = busy_r;
    otp_nxt = otp_r;
    tmr_nxt = tmr_r;
    if (busy_r) begin
      if (tmr_r == 32'h0) begin
        busy_nxt = 1'b0;
        wel_nxt  = 1'b0;
      end else begin
        tmr_nxt = tmr_r - 32'h1;
      end
    end
    if (cs_hi) begin
      // select high ends any command and releases the output
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      if (st_r == ST_ARMED) begin
        case (op_r)
          CMD_SET_LATCH: begin
            if (!busy_r) wel_nxt = 1'b1;
          end
          CMD_CLR_LATCH: begin
            if (!busy_r) begin
              wel_nxt = 1'b0;
              otp_nxt = 1'b0;
            end
          end
          CMD_OTP_ENTER: begin
            if (!busy_r) otp_nxt = 1'b1;
          end
          CMD_STATUS_WRITE: begin
            if (wel_r && !busy_r && !hardware_protected_mode) begin
              if (otp_r) begin
                lock_nxt = 1'b1;
              end else begin
                srp_nxt  = sh_r[ST_LOCK_B];
                pdis_nxt = sh_r[ST_PDIS_B];
                bp_nxt   = sh_r[ST_BP_LO+3:ST_BP_LO];
              end
              busy_nxt = 1'b1;
              tmr_nxt  = 32'(WR_CYC - 1);
            end
          end
          CMD_CHIP_ERASE: begin
            if (wel_r && !busy_r && bp_r == 4'h0) begin
              busy_nxt = 1'b1;
              tmr_nxt  = 32'(CE_CYC - 1);
            end
          end
          default: ;
        endcase
      end
    end else if (cs_fall) begin
      st_nxt  = ST_OP;
      cnt_nxt = 5'h0;
      oe_nxt  = 1'b0;
    end else if (sclk_rise) begin
      case (st_r)
        ST_OP: begin
          sh_nxt  = sh_rx;
          cnt_nxt = cnt_r + 5'h1;
          if (cnt_r == 5'(OPC_BITS - 1)) begin
            cnt_nxt  = 5'h0;
            ocnt_nxt = 3'h0;
            op_nxt   = sh_rx;
            case (sh_rx)
              CMD_STATUS_READ:  st_nxt = ST_STAT;
              CMD_ARRAY_READ:   st_nxt = busy_r ? ST_SKIP : ST_ADDR;
              CMD_STATUS_WRITE: st_nxt = busy_r ? ST_SKIP : ST_WDATA;
              CMD_SET_LATCH, CMD_CLR_LATCH, CMD_CHIP_ERASE, CMD_OTP_ENTER:
                st_nxt = ST_ARMED;
              default:          st_nxt = ST_SKIP;
            endcase
          end
        end
        ST_ADDR: begin
          // only the low address bits reach the array
          addr_nxt = {addr_r[ADDR_W-2:0], si};
          cnt_nxt  = cnt_r + 5'h1;
          if (cnt_r == 5'(ADDR_BITS - 1)) st_nxt = ST_READ;
        end
        ST_WDATA: begin
          sh_nxt  = sh_rx;
          cnt_nxt = cnt_r + 5'h1;
          if (cnt_r == 5'(OPC_BITS - 1)) st_nxt = ST_ARMED;
        end
        // any clock beyond the last expected bit voids the command
        ST_ARMED: st_nxt = ST_SKIP;
        default: ;
      endcase
    end else if (sclk_fall && (st_r == ST_STAT || st_r == ST_READ)) begin
      oe_nxt   = 1'b1;
      ocnt_nxt = ocnt_r + 3'h1;
      if (ocnt_r == 3'h0) begin
        // byte taken live, so repeated status bytes track busy
        so_nxt = src[7];
        tx_nxt = {src[6:0], 1'b0};
      end else begin
        so_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
      if (ocnt_r == 3'h7 && st_r == ST_READ) begin
        addr_nxt = addr_r + 19'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_r <= PIN_RST;
      sy2_r <= PIN_RST;
      sy3_r <= PIN_RST;
      pin_r <= PIN_RST;
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      tx_r <= 8'h00;
      cnt_r <= 5'h00;
      ocnt_r <= 3'h0;
      addr_r <= '0;
      so_r <= 1'b0;
      oe_r <= 1'b0;
      srp_r <= NV_RST;
      lock_r <= NV_RST;
      pdis_r <= NV_RST;
      bp_r <= 4'h0;
      wel_r <= 1'b0;
      busy_r <= 1'b0;
      otp_r <= 1'b0;
      tmr_r <= 32'h0;
      status_q <= 8'h00;
    end else begin
      sy1_r <= {spi.wp_n, spi.serial_in, spi.chip_sel_n, spi.sclk};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= pin_nxt;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      tx_r <= tx_nxt;
      cnt_r <= cnt_nxt;
      ocnt_r <= ocnt_nxt;
      addr_r <= addr_nxt;
      so_r <= so_nxt;
      oe_r <= oe_nxt;
      srp_r <= srp_nxt;
      lock_r <= lock_nxt;
      pdis_r <= pdis_nxt;
      bp_r <= bp_nxt;
      wel_r <= wel_nxt;
      busy_r <= busy_nxt;
      otp_r <= otp_nxt;
      tmr_r <= tmr_nxt;
      status_q <= stat_now;
    end
  end

  assign spi.serial_out    = so_r;
  assign spi.serial_out_oe = oe_r;
  assign otp_mode_q        = otp_r;
endmodule : fsr_flash_dev

// ===== rtl/fsr_spi_host.sv
// host controller end: APB registers driving one serial frame at a time
`timescale 1ns/1ns
module fsr_spi_host import fsr_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  fsr_spi_if.host          spi
);
  logic [23:0] cmd_r, cmd_nxt, addr_r, addr_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic [31:0] rx_r, rx_nxt, prdata_nxt;
  logic [39:0] tx_r, tx_nxt;
  logic [11:0] bits_r, bits_nxt, cnt_r, cnt_nxt;
  logic [7:0]  div_r, div_nxt;
  logic        wp_r, wp_nxt, busy_r, busy_nxt, sclk_r, sclk_nxt;
  logic        cs_r, cs_nxt, mosi_r, mosi_nxt, rdy_nxt, err_nxt;
  logic [3:0]  sy1_r, sy2_r, sy3_r, in_r, in_nxt;
  logic        acc, wr, tick, mapped;

  assign acc    = psel & penable & ~pready;
  assign wr     = psel & penable & pready & pwrite;
  assign mapped = paddr inside {REG_CMD, REG_ADDR, REG_WDATA, REG_RDATA, REG_CTRL, REG_STAT};
  assign tick   = busy_r && div_r == 8'(HALF_CYC - 1);
  assign in_nxt = fsr_filt(sy2_r, sy3_r, in_r);

  always_comb begin
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    bits_nxt = bits_r;
    cnt_nxt = cnt_r;
    wp_nxt = wp_r;
    busy_nxt = busy_r;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    mosi_nxt = mosi_r;
    div_nxt = busy_r ? (tick ? 8'h0 : div_r + 8'h1) : 8'h0;
    rdy_nxt = acc;
    err_nxt = acc & ~mapped;
    prdata_nxt = 32'h0;
    if (acc) begin
      case (paddr)
        REG_CMD:   prdata_nxt = {8'h0, cmd_r};
        REG_ADDR:  prdata_nxt = {8'h0, addr_r};
        REG_WDATA: prdata_nxt = {24'h0, wdat_r};
        REG_RDATA: prdata_nxt = rx_r;
        REG_CTRL:  prdata_nxt = {31'h0, wp_r};
        REG_STAT:  prdata_nxt = {31'h0, busy_r};
        default:   prdata_nxt = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr)
        REG_ADDR:  addr_nxt = pwdata[23:0];
        REG_WDATA: wdat_nxt = pwdata[7:0];
        REG_CTRL:  wp_nxt = pwdata[0];
        REG_CMD: begin
          // a frame order while a frame runs is dropped
          if (!busy_r) begin
            cmd_nxt  = pwdata[23:0];
            tx_nxt   = pwdata[CMD_ADDR_B] ? {pwdata[7:0], addr_r, wdat_r}
                                          : {pwdata[7:0], wdat_r, 24'h0};
            bits_nxt = 12'(OPC_BITS) + (pwdata[CMD_ADDR_B] ? 12'(ADDR_BITS) : 12'h0)
                     + (pwdata[CMD_DATA_B] ? 12'h8 : 12'h0)
                     + {1'b0, pwdata[CMD_RCNT_LO+7:CMD_RCNT_LO], 3'h0};
            busy_nxt = 1'b1;
            cs_nxt   = 1'b0;
            sclk_nxt = 1'b0;
            cnt_nxt  = 12'h0;
            mosi_nxt = pwdata[7];
          end
        end
        default: ;
      endcase
    end else if (tick) begin
      if (!sclk_r) begin
        sclk_nxt = 1'b1;
        rx_nxt   = {rx_r[30:0], in_r[0]};
        cnt_nxt  = cnt_r + 12'h1;
      end else begin
        sclk_nxt = 1'b0;
        if (cnt_r == bits_r) begin
          // select rises right after the last bit, ending any read
          cs_nxt   = 1'b1;
          busy_nxt = 1'b0;
        end else begin
          tx_nxt   = {tx_r[38:0], 1'b0};
          mosi_nxt = tx_r[38];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 24'h0;
      addr_r <= 24'h0;
      wdat_r <= 8'h00;
      rx_r <= 32'h0;
      tx_r <= 40'h0;
      bits_r <= 12'h0;
      cnt_r <= 12'h0;
      div_r <= 8'h00;
      wp_r <= 1'b1;
      busy_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      mosi_r <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sy1_r <= 4'hF;
      sy2_r <= 4'hF;
      sy3_r <= 4'hF;
      in_r <= 4'hF;
    end else begin
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      bits_r <= bits_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      wp_r <= wp_nxt;
      busy_r <= busy_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      mosi_r <= mosi_nxt;
      prdata <= prdata_nxt;
      pready <= rdy_nxt;
      pslverr <= err_nxt;
      sy1_r <= {3'h7, spi.miso};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      in_r <= in_nxt;
    end
  end

  assign spi.sclk       = sclk_r;
  assign spi.chip_sel_n = cs_r;
  assign spi.serial_in  = mosi_r;
  assign spi.wp_n       = wp_r;
endmodule : fsr_spi_host

// ===== tb/fsr_link_checker.sv
// link protocol checker for the serial flash status and read path
`timescale 1ns/1ns
module fsr_link_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic sclk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  input wire logic wp_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       sclk_d_r;
  logic       sclk_d_nxt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // sclk rises seen in the current frame; cleared while deselected
  always_comb begin
    sclk_d_nxt = sclk;
    cnt_nxt    = chip_sel_n ? 8'h00 : cnt_r + {7'h00, sclk & ~sclk_d_r};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 8'h00;
      sclk_d_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      sclk_d_r <= sclk_d_nxt;
    end
  end

  idle_sclk_a: assert property (chip_sel_n |-> !sclk)
    else $error("serial clock not low while deselected");
  whole_bytes_a: assert property ($rose(chip_sel_n) |-> cnt_r[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  oe_release_a: assert property ($rose(chip_sel_n) |-> ##[1:8] !serial_out_oe)
    else $error("output still driven after deselect");
  oe_idle_a: assert property (chip_sel_n [*8] |-> !serial_out_oe)
    else $error("output driven while deselected");
  oe_opcode_a: assert property ($fell(chip_sel_n) |-> !serial_out_oe [*8])
    else $error("output driven during opcode");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  si_stable_a: assert property (sclk && $past(sclk) |-> $stable(serial_in))
    else $error("input data changed while clock high");
  so_stable_a: assert property (sclk && $past(sclk) && serial_out_oe && $past(serial_out_oe)
                                |-> $stable(serial_out))
    else $error("output data changed while clock high");

  cover property ($rose(serial_out_oe));
  cover property ($rose(chip_sel_n) && cnt_r == 8'h10);
  cover property ($rose(chip_sel_n) && cnt_r == 8'h40);
  // a two-byte frame, such as a status write or status read, ended with the protect pin held low
  cover property ($rose(chip_sel_n) && !wp_n && cnt_r == 8'h10);
endmodule : fsr_link_checker

// ===== tb/flash_status_and_read_access_tb.sv
// self-checking bench joining host controller and flash device over the serial link
`timescale 1ns/1ns
module flash_status_and_read_access_tb import fsr_pkg::*; ;
  logic              pclk = 1'b0;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              load_en;
  logic [ADDR_W-1:0] load_addr;
  logic [7:0]        load_data;
  int                mismatches;
  int                cmp_count;
  logic [31:0]       seed;
  logic [31:0]       r;
  logic              e;
  logic [7:0]        s;
  logic [7:0]        d;
  logic [7:0]        b [8];
  logic [18:0]       base;
  logic [7:0]        stq;
  logic              otpq;

  always #50 pclk = ~pclk;

  fsr_spi_if u_fsr_spi_if ();
  // short write and erase cycles keep the busy polling affordable
  fsr_flash_dev #(.WR_CYC(2500), .CE_CYC(1000)) u_fsr_flash_dev (.pclk(pclk),
    .presetn(presetn), .spi(u_fsr_spi_if.dev), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .status_q(stq), .otp_mode_q(otpq));
  fsr_spi_host u_fsr_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi(u_fsr_spi_if.host));
  fsr_link_checker u_fsr_link_checker (.pclk(pclk), .presetn(presetn),
    .sclk(u_fsr_spi_if.sclk), .chip_sel_n(u_fsr_spi_if.chip_sel_n),
    .serial_in(u_fsr_spi_if.serial_in), .wp_n(u_fsr_spi_if.wp_n),
    .serial_out(u_fsr_spi_if.serial_out), .serial_out_oe(u_fsr_spi_if.serial_out_oe));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // status after a write: low two bits are never taken from the data
  function automatic logic [7:0] wexp(input logic [7:0] x);
    return {x[7:2], 2'b00};
  endfunction : wexp

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one wait state: pready answers on the second access-phase edge
    chk(32'(n), 32'h2);
  endtask : apb
  // one frame, waits for the host to go idle, leaves the shifted-in word in r
  task automatic cmd(input logic [31:0] c, input logic [31:0] a, input logic [31:0] wd);
    int n;
    apb(1'b1, REG_ADDR, a);
    apb(1'b1, REG_WDATA, wd);
    apb(1'b1, REG_CMD, c);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    chk(32'(r[0]), 32'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : cmd
  task automatic rstat();
    cmd(32'h0001_0005, 32'h0, 32'h0);
    s = r[7:0];
  endtask : rstat
  task automatic sc(input logic [7:0] x);
    rstat();
    chk(32'(s), 32'(x));
    chk(32'(stq), 32'(x));
  endtask : sc
  task automatic idle();
    int n;
    n = 0;
    do begin
      rstat();
      n++;
    end while (s[0] !== 1'b0 && n < 30);
    chk(32'(s[0]), 32'h0);
  endtask : idle
  task automatic wsr(input logic [7:0] x);
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0000_0201, 32'h0, 32'(x));
    idle();
  endtask : wsr
  task automatic load(input logic [18:0] a, input logic [7:0] x);
    @(posedge pclk);
    load_en   <= 1'b1;
    load_addr <= a;
    load_data <= x;
    @(posedge pclk);
    load_en <= 1'b0;
  endtask : load

  initial begin
    repeat (95000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  initial begin
    seed = 32'hA1C2;
    mismatches = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load_en = 1'b0;
    load_addr = '0;
    load_data = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    r = rnd();
    base = {3'b001, r[15:0]};
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      b[i] = r[7:0];
      b[i+4] = r[15:8];
      load(19'h7FFFE + 19'(i), b[i]);
      load(base + 19'(i), b[i+4]);
    end
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({r[31:1], e}, 32'h1);
    sc(8'h00);
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0002_0005, 32'h0, 32'h0);
    chk(32'(r[15:0]), 32'h0202);
    cmd(32'h0000_0004, 32'h0, 32'h0);
    sc(8'h00);
    cmd(32'h0000_0201, 32'h0, 32'h3C);
    sc(8'h00);
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0000_0001, 32'h0, 32'h0);
    sc(8'h02);
    cmd(32'h0000_0004, 32'h0, 32'h0);
    r = rnd();
    d = (r[7:0] & 8'h3F) | 8'h03;
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0000_0201, 32'h0, 32'(d));
    rstat();
    chk(32'(s[1:0]), 32'h3);
    cmd(32'h0001_0103, 32'(base), 32'h0);
    chk(32'(r[7:0]), 32'hFF);
    idle();
    sc(wexp(d));
    wsr(8'hC0);
    apb(1'b1, REG_CTRL, 32'h0);
    wsr(8'h88);
    sc(8'h88);
    wsr(8'h3C);
    chk(32'(s[7:2]), 32'h22);
    cmd(32'h0000_0004, 32'h0, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    wsr(8'h08);
    sc(8'h08);
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0000_0060, 32'h0, 32'h0);
    rstat();
    chk(32'(s[0]), 32'h0);
    cmd(32'h0000_0004, 32'h0, 32'h0);
    wsr(8'h00);
    cmd(32'h0000_0006, 32'h0, 32'h0);
    cmd(32'h0000_0060, 32'h0, 32'h0);
    rstat();
    chk(32'(s[0]), 32'h1);
    idle();
    sc(8'h00);
    r = rnd();
    cmd(32'h0004_0103, {8'h00, r[4:0], 19'h7FFFE}, 32'h0);
    chk(r, {b[0], b[1], b[2], b[3]});
    cmd(32'h0004_0103, 32'(base), 32'h0);
    chk(r, {b[4], b[5], b[6], b[7]});
    cmd(32'h0001_0103, 32'(base), 32'h0);
    chk(32'(r[7:0]), 32'(b[4]));
    sc(8'h00);
    cmd(32'h0000_003A, 32'h0, 32'h0);
    wsr(8'h00);
    sc(8'h80);
    chk(32'(otpq), 32'h1);
    cmd(32'h0000_0004, 32'h0, 32'h0);
    sc(8'h00);
    chk(32'(otpq), 32'h0);
    summarize();
  end
endmodule : flash_status_and_read_access_tb
